// [ac_angle_calc.sv]
// Angle post-processing path: filter, arctangent, offsets, gain, linearization
//
// Function
// - Both channels pass a hysteresis filter with a 0..1023 LSB window first.
// - Filtered channel values are readable as 16-bit words over the register port.
// - Without bypass the angle is a CORDIC two-argument arctangent.
// - Order bit swaps sine/cosine roles, or picks channel in bypass.
// - Bypass adds 32768 to the signed channel value to form the angle.
// - Arctangent quadrants: (0,1)=0, (1,0)=90, (0,-1)=180, (-1,0)=270 degrees.
// - Direction bit replaces the angle with 360 minus the angle.
// - Pre-gain offset of 15 bits adds modulo 360, always wrapping.
// - Optional 8-bit low/high limits set only the saturation flag.
// - Gain is unsigned 6.10 fixed point; zero gain gives zero output.
// - Without gain saturation the gained angle wraps modulo 360.
// - With gain saturation overflow holds full scale, past rollover gives zero.
// - Rollover point is an 8-bit setting compared against the pre-gain angle.
// - Gain saturation resets enabled and rollover resets to zero.
// - Post-gain offset wraps, or clamps to 0..full scale; clamp resets enabled.
// - Post-gain offset is signed 16 bits of 720/65536 degrees.
// - Order: atan/bypass, direction, pre offset, gain, post offset, linearization.
// - Linearization holds 33 fixed points or configurable segment positions.
// - Two-bit mode picks fixed lin, fixed bin, variable lin, variable bin.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "ac_defs.svh"

module ac_angle_calc #(
  parameter int HYST_W = 10
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Channel samples from the trim path
  input wire logic sample_valid_i,
  input wire logic [15:0] first_axis_raw_i,
  input wire logic [15:0] second_axis_raw_i,
  // Register port
  input wire logic [8:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Angle result
  output logic [15:0] angle_o,
  output logic angle_valid_o,
  output logic sat_flag_o,
  output logic busy_o
);
  import ac_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [9:0] ctrl_r;
  logic [31:0] hyst_r;
  logic [14:0] pre_offs_r;
  logic [23:0] limits_r;
  logic [15:0] gain_r;
  logic [15:0] post_offs_r;
  logic [12:0] coeff_r [`AC_COEFF_NUM];

  wire cfg_bypass = ctrl_r[`AC_CTRL_BYPASS];
  wire cfg_order = ctrl_r[`AC_CTRL_ORDER];
  wire cfg_dir_inv = ctrl_r[`AC_CTRL_DIR_INV];
  wire cfg_thr_en = ctrl_r[`AC_CTRL_THR_EN];
  wire cfg_gsat_en = ctrl_r[`AC_CTRL_GSAT_EN];
  wire cfg_osat_en = ctrl_r[`AC_CTRL_OSAT_EN];
  wire [1:0] cfg_lin = ctrl_r[`AC_CTRL_LIN_LSB +: 2];
  wire [1:0] cfg_scale = ctrl_r[`AC_CTRL_SCALE_LSB +: 2];
  wire [7:0] thr_low = limits_r[7:0];
  wire [7:0] thr_high = limits_r[15:8];
  wire [7:0] roll_pt = limits_r[23:16];

  wire wr_en = ce_i & reg_wr_i;
  wire wr_ctrl = wr_en && (reg_addr_i == `AC_ADDR_CTRL);
  wire wr_hyst = wr_en && (reg_addr_i == `AC_ADDR_HYST);
  wire wr_pre = wr_en && (reg_addr_i == `AC_ADDR_PRE_OFFS);
  wire wr_lim = wr_en && (reg_addr_i == `AC_ADDR_LIMITS);
  wire wr_gain = wr_en && (reg_addr_i == `AC_ADDR_GAIN);
  wire wr_post = wr_en && (reg_addr_i == `AC_ADDR_POST_OFFS);
  // Word index into the table, counted from its base address
  wire [8:0] coeff_off = reg_addr_i - `AC_ADDR_COEFF;
  wire [6:0] coeff_idx = coeff_off[8:2];
  wire coeff_hit = (reg_addr_i >= `AC_ADDR_COEFF) && (coeff_idx < 7'(`AC_COEFF_NUM));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `AC_CTRL_RST;
      hyst_r <= 32'h0;
      pre_offs_r <= 15'h0;
      limits_r <= {`AC_ROLL_RST, 16'h0};
      gain_r <= `AC_GAIN_RST;
      post_offs_r <= 16'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata_i[9:0];
      if (wr_hyst) hyst_r <= reg_wdata_i;
      if (wr_pre) pre_offs_r <= reg_wdata_i[14:0];
      if (wr_lim) limits_r <= reg_wdata_i[23:0];
      if (wr_gain) gain_r <= reg_wdata_i[15:0];
      if (wr_post) post_offs_r <= reg_wdata_i[15:0];
    end
  end

  // Table kept without reset so it maps onto plain storage
  always_ff @(posedge sys_clk_i) begin
    if (wr_en && coeff_hit) begin
      coeff_r[coeff_idx[5:0]] <= reg_wdata_i[12:0];
    end
  end

  // ----------------------------------------------------------------
  // Hysteresis filters, one per channel
  // ----------------------------------------------------------------
  wire [1:0][15:0] filt_w;
  wire [1:0][15:0] raw_w = {second_axis_raw_i, first_axis_raw_i};

  // A reversal inside the window holds the output; leaving it moves the head across
  for (genvar g = 0; g < 2; g++) begin : g_hyst
    logic [15:0] filt_r;
    logic up_r;
    logic seen_r;
    wire [HYST_W-1:0] win = hyst_r[g*16 +: HYST_W];
    wire signed [16:0] diff = $signed({raw_w[g][15], raw_w[g]}) - $signed({filt_r[15], filt_r});
    wire signed [16:0] win_s = $signed(17'(win));
    wire fwd = up_r ? (diff > 17'sh0) : (diff < 17'sh0);
    wire flip = up_r ? (diff < -win_s) : (diff > win_s);
    wire first = !seen_r && (diff != 17'sh0);
    wire take = (win == '0) || first || fwd || flip;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        filt_r <= 16'h0;
        up_r <= 1'b1;
        seen_r <= 1'b0;
      end else if (ce_i && sample_valid_i) begin
        if (take) filt_r <= raw_w[g];
        if (first || flip) up_r <= (diff > 17'sh0);
        if (first) seen_r <= 1'b1;
      end
    end
    assign filt_w[g] = filt_r;
  end

  wire [15:0] first_axis_filtered = filt_w[0];
  wire [15:0] second_axis_filtered = filt_w[1];

  // ----------------------------------------------------------------
  // Sequencer and CORDIC
  // ----------------------------------------------------------------
  ac_state_t state_r;
  ac_state_t state_nxt;
  logic [3:0] it_r;
  logic signed [19:0] x_r;
  logic signed [19:0] y_r;
  logic [15:0] z_r;

  function automatic logic [15:0] ac_atan(input logic [3:0] i);
    case (i)
      4'h0: ac_atan = 16'h2000;
      4'h1: ac_atan = 16'h12E4;
      4'h2: ac_atan = 16'h09FB;
      4'h3: ac_atan = 16'h0511;
      4'h4: ac_atan = 16'h028B;
      4'h5: ac_atan = 16'h0146;
      4'h6: ac_atan = 16'h00A3;
      4'h7: ac_atan = 16'h0051;
      4'h8: ac_atan = 16'h0029;
      4'h9: ac_atan = 16'h0014;
      4'hA: ac_atan = 16'h000A;
      4'hB: ac_atan = 16'h0005;
      4'hC: ac_atan = 16'h0003;
      4'hD: ac_atan = 16'h0001;
      4'hE: ac_atan = 16'h0001;
      default: ac_atan = 16'h0000;
    endcase
  endfunction

  // Order bit decides which channel plays sine
  wire [15:0] sin_in = cfg_order ? second_axis_filtered : first_axis_filtered;
  wire [15:0] cos_in = cfg_order ? first_axis_filtered : second_axis_filtered;
  wire signed [19:0] sin_ext = 20'(signed'(sin_in));
  wire signed [19:0] cos_ext = 20'(signed'(cos_in));
  wire cos_neg = cos_ext < 20'sh0;
  // Pre-rotation by half a turn keeps the vector in the right half plane
  wire signed [19:0] x_load = cos_neg ? -cos_ext : cos_ext;
  wire signed [19:0] y_load = cos_neg ? -sin_ext : sin_ext;
  wire [15:0] z_load = cos_neg ? `AC_ANGLE_HALF : 16'h0;
  // Offset binary: most negative reads as zero angle
  wire [15:0] byp_angle = sin_in ^ `AC_ANGLE_HALF;
  // Arithmetic shifts round toward minus infinity; the error stays in the last bits
  wire signed [19:0] x_sh = x_r >>> it_r;
  wire signed [19:0] y_sh = y_r >>> it_r;
  wire y_pos = y_r >= 20'sh0;
  // Sixteen steps suit 16-bit codes; table rounding may cost a few codes
  wire last_it = (it_r == 4'(`AC_CORDIC_ITER - 1));

  // Samples seen while busy still feed the filters but start nothing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AC_IDLE: if (sample_valid_i) state_nxt = AC_LOAD;
      AC_LOAD: state_nxt = cfg_bypass ? AC_DONE : AC_ITER;
      AC_ITER: if (last_it) state_nxt = AC_DONE;
      AC_DONE: state_nxt = AC_IDLE;
      default: state_nxt = AC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= AC_IDLE;
      it_r <= 4'h0;
      x_r <= 20'sh0;
      y_r <= 20'sh0;
      z_r <= 16'h0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      if (state_r == AC_LOAD) begin
        it_r <= 4'h0;
        x_r <= x_load;
        y_r <= y_load;
        z_r <= cfg_bypass ? byp_angle : z_load;
      end else if (state_r == AC_ITER) begin
        it_r <= it_r + 4'h1;
        x_r <= y_pos ? x_r + y_sh : x_r - y_sh;
        y_r <= y_pos ? y_r - x_sh : y_r + x_sh;
        z_r <= y_pos ? z_r + ac_atan(it_r) : z_r - ac_atan(it_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // Angle chain, evaluated on the finished raw angle
  // ----------------------------------------------------------------
  wire [15:0] ang0 = z_r;
  wire [15:0] ang1 = cfg_dir_inv ? 16'h0 - ang0 : ang0;
  wire [15:0] ang2 = ang1 + {pre_offs_r, 1'b0};
  wire thr_lo = ang2[15:8] < thr_low;
  wire thr_hi = ang2[15:8] > thr_high;
  wire thr_hit = cfg_thr_en && (thr_lo || thr_hi);

  wire [31:0] prod = ang2 * gain_r;
  wire [21:0] prod_int = prod[31:10];
  wire g_ovf = prod_int[21:16] != 6'h0;
  wire past_roll = ang2 > {roll_pt, 8'h0};
  // Overflow is tested first, so a low rollover never cuts the linear part
  logic [15:0] ang3;
  always_comb begin
    if (!g_ovf || !cfg_gsat_en) begin
      ang3 = prod_int[15:0];
    end else if (past_roll) begin
      ang3 = 16'h0;
    end else begin
      ang3 = `AC_ANGLE_MAX;
    end
  end

  // Post offset counts two angle codes per step
  wire signed [18:0] post_add = $signed({post_offs_r[15], post_offs_r[15], post_offs_r, 1'b0});
  wire signed [18:0] post_sum = $signed({3'b000, ang3}) + post_add;
  logic [15:0] ang4;
  always_comb begin
    if (!cfg_osat_en) begin
      ang4 = post_sum[15:0];
    end else if (post_sum < 19'sh0) begin
      ang4 = 16'h0;
    end else if (post_sum > 19'sh0FFFF) begin
      ang4 = `AC_ANGLE_MAX;
    end else begin
      ang4 = post_sum[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Linearization and binning
  // ----------------------------------------------------------------
  wire [4:0] seg = ang4[15:11];
  wire [10:0] frac = ang4[10:0];
  wire signed [13:0] y_lo = 14'(signed'(coeff_r[seg]));
  wire [5:0] seg_nxt = 6'(seg) + 6'h1;
  wire signed [13:0] y_hi = 14'(signed'(coeff_r[seg_nxt]));
  wire signed [13:0] y_dlt = y_hi - y_lo;
  wire signed [25:0] y_mul = y_dlt * $signed({1'b0, frac});
  wire signed [13:0] y_fix = y_lo + 14'(y_mul >>> 11);

  // X points should rise; one that falls only shifts the count
  logic [4:0] var_cnt;
  always_comb begin
    var_cnt = 5'h0;
    for (int j = 0; j < `AC_VAR_POINTS; j++) begin
      if (coeff_r[j/2][(j%2)*6 +: 6] <= ang4[15:10]) var_cnt = var_cnt + 5'h1;
    end
  end
  wire [5:0] var_sel = (var_cnt == 5'h0) ? 6'(`AC_VAR_Y_BASE) :
                       6'(`AC_VAR_Y_BASE) + 6'(var_cnt) - 6'h1;
  wire signed [13:0] y_var = 14'(signed'(coeff_r[var_sel]));

  // Codes are negated corrections; scale selects 2, 4, 8 or 16 codes per step
  wire signed [13:0] corr = (cfg_lin == AC_LIN_FIXED) ? y_fix : y_var;
  wire [2:0] corr_shamt = 3'(cfg_scale) + 3'h1;
  wire signed [19:0] corr_sh = 20'(corr) <<< corr_shamt;
  wire signed [19:0] lin_sum = $signed({4'h0, ang4}) - corr_sh;
  wire [15:0] lin_clip = (lin_sum < 20'sh0) ? 16'h0 :
                         (lin_sum > 20'sh0FFFF) ? `AC_ANGLE_MAX : lin_sum[15:0];
  logic [15:0] ang5;
  always_comb begin
    case (cfg_lin)
      AC_LIN_FIXED: ang5 = lin_clip;
      AC_BIN_FIXED: ang5 = {coeff_r[seg], 3'h0};
      AC_LIN_VAR: ang5 = lin_clip;
      AC_BIN_VAR: ang5 = (var_cnt == 5'h0) ? 16'h0 : {coeff_r[var_sel], 3'h0};
      default: ang5 = ang4;
    endcase
  end
  wire [15:0] ang_final = (gain_r == 16'h0) ? 16'h0 : ang5;

  // ----------------------------------------------------------------
  // Result and read-back
  // ----------------------------------------------------------------
  // Angle and flag move together, only when a result is finished
  logic [15:0] angle_r;
  logic valid_r;
  logic sat_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      angle_r <= 16'h0;
      valid_r <= 1'b0;
      sat_r <= 1'b0;
    end else if (ce_i) begin
      valid_r <= (state_r == AC_DONE);
      if (state_r == AC_DONE) begin
        angle_r <= ang_final;
        sat_r <= thr_hit;
      end
    end
  end

  wire [31:0] coeff_rd = coeff_hit ? {19'h0, coeff_r[coeff_idx[5:0]]} : 32'h0;
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      `AC_ADDR_CTRL: rd_mux = {22'h0, ctrl_r};
      `AC_ADDR_HYST: rd_mux = hyst_r;
      `AC_ADDR_PRE_OFFS: rd_mux = {17'h0, pre_offs_r};
      `AC_ADDR_LIMITS: rd_mux = {8'h0, limits_r};
      `AC_ADDR_GAIN: rd_mux = {16'h0, gain_r};
      `AC_ADDR_POST_OFFS: rd_mux = {16'h0, post_offs_r};
      `AC_ADDR_STATUS: rd_mux = {30'h0, state_r != AC_IDLE, sat_r};
      `AC_ADDR_AXIS: rd_mux = {second_axis_filtered, first_axis_filtered};
      `AC_ADDR_ANGLE: rd_mux = {16'h0, angle_r};
      default: rd_mux = coeff_rd;
    endcase
  end

  // Zero between answers, so a stale word is never taken for a new one
  logic [31:0] rdata_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0;
    end else if (ce_i) begin
      rdata_r <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign angle_o = angle_r;
  assign angle_valid_o = valid_r;
  assign sat_flag_o = sat_r;
  assign busy_o = (state_r != AC_IDLE);

endmodule

// [ac_defs.svh]
// Offsets, field positions, reset values and counts of the angle post-processing path
`ifndef AC_DEFS_SVH
`define AC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define AC_ADDR_CTRL 9'h000
`define AC_ADDR_HYST 9'h004
`define AC_ADDR_PRE_OFFS 9'h008
`define AC_ADDR_LIMITS 9'h00C
`define AC_ADDR_GAIN 9'h010
`define AC_ADDR_POST_OFFS 9'h014
`define AC_ADDR_STATUS 9'h018
`define AC_ADDR_AXIS 9'h01C
`define AC_ADDR_ANGLE 9'h020
`define AC_ADDR_COEFF 9'h080

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define AC_CTRL_BYPASS 0
`define AC_CTRL_ORDER 1
`define AC_CTRL_DIR_INV 2
`define AC_CTRL_THR_EN 3
`define AC_CTRL_GSAT_EN 4
`define AC_CTRL_OSAT_EN 5
`define AC_CTRL_LIN_LSB 6
`define AC_CTRL_SCALE_LSB 8

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define AC_CTRL_RST 10'h030
`define AC_GAIN_RST 16'h0400
`define AC_ROLL_RST 8'h00
`define AC_COEFF_NUM 33
`define AC_VAR_POINTS 22
`define AC_VAR_Y_BASE 11
`define AC_CORDIC_ITER 16
`define AC_ANGLE_MAX 16'hFFFF
`define AC_ANGLE_HALF 16'h8000

`endif

// [ac_pkg.sv]
// Types shared by the angle post-processing path
package ac_pkg;

  typedef enum logic [3:0] {
    AC_IDLE = 4'b0001,
    AC_LOAD = 4'b0010,
    AC_ITER = 4'b0100,
    AC_DONE = 4'b1000
  } ac_state_t;

  typedef enum logic [1:0] {
    AC_LIN_FIXED = 2'h0,
    AC_BIN_FIXED = 2'h1,
    AC_LIN_VAR = 2'h2,
    AC_BIN_VAR = 2'h3
  } ac_lin_mode_t;

endpackage

// [ac_angle_calc_monitor.sv]
// Port-level checks of the angle post-processing path
`timescale 1ns/1ps
`include "ac_defs.svh"

module ac_angle_calc_monitor (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Samples
  input wire logic sample_valid_i,
  input wire logic [15:0] first_axis_raw_i,
  input wire logic [15:0] second_axis_raw_i,
  // Register port
  input wire logic [8:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Result
  input wire logic [15:0] angle_o,
  input wire logic angle_valid_o,
  input wire logic sat_flag_o,
  input wire logic busy_o
);
  import ac_pkg::*;
  // ----------------------------------------------------------------
  // Shadow of control and gain, rebuilt from port writes
  // ----------------------------------------------------------------
  logic [9:0] ctrl_r;
  logic [15:0] gain_r;
  wire logic wr_ok = ce_i && reg_wr_i;
  wire logic start = ce_i && sample_valid_i && !busy_o;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `AC_CTRL_RST;
      gain_r <= `AC_GAIN_RST;
    end else begin
      if (wr_ok && reg_addr_i == `AC_ADDR_CTRL) ctrl_r <= reg_wdata_i[9:0];
      if (wr_ok && reg_addr_i == `AC_ADDR_GAIN) gain_r <= reg_wdata_i[15:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_idle_zero_a: assert property (
    $past(ce_i) && !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  unmapped_rd_a: assert property (
    $past(ce_i) && $past(reg_rd_i) && $past(reg_addr_i) inside {[9'h024:9'h07C]}
    |-> reg_rdata_o == 32'h0) else $error("unmapped read returned data");
  bypass_lat_a: assert property (
    start && ctrl_r[0] |=> !angle_valid_o ##1 !angle_valid_o ##1 angle_valid_o)
    else $error("bypass result not three cycles after sample");
  cordic_lat_a: assert property (
    start && !ctrl_r[0] |-> ##19 angle_valid_o) else $error("arctangent result late");
  cordic_busy_a: assert property (
    start && !ctrl_r[0] |=> busy_o [*8]) else $error("busy dropped during iteration");
  valid_pulse_a: assert property (
    angle_valid_o |=> !angle_valid_o) else $error("valid longer than one cycle");
  valid_idle_a: assert property (
    angle_valid_o |-> !busy_o) else $error("busy at result");
  angle_hold_a: assert property (
    !angle_valid_o |-> $stable(angle_o)) else $error("angle changed without valid");
  flag_hold_a: assert property (
    !angle_valid_o |-> $stable(sat_flag_o)) else $error("flag changed without valid");
  flag_off_a: assert property (
    angle_valid_o && !ctrl_r[3] |-> !sat_flag_o) else $error("flag set with limits off");
  gain_zero_a: assert property (
    angle_valid_o && gain_r == 16'h0 |-> angle_o == 16'h0) else $error("zero gain not zero");
endmodule

// [tb_top.sv]
// Self-checking testbench of the angle post-processing path
`timescale 1ns/1ps
`include "ac_defs.svh"

module tb_top;
  import ac_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic sample_valid_i = 1'b0;
  logic [15:0] first_axis_raw_i = 16'h0;
  logic [15:0] second_axis_raw_i = 16'h0;
  logic [8:0] reg_addr_i = 9'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [15:0] angle_o;
  logic angle_valid_o;
  logic sat_flag_o;
  logic busy_o;
  logic [15:0] lin_exp [4] = '{16'h8E00, 16'h0800, 16'h8E00, 16'h0800};
  int n_fail = 0;
  int n_tests = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  ac_angle_calc u_ac_angle_calc (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sample_valid_i(sample_valid_i),
    .first_axis_raw_i(first_axis_raw_i), .second_axis_raw_i(second_axis_raw_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .angle_o(angle_o),
    .angle_valid_o(angle_valid_o), .sat_flag_o(sat_flag_o), .busy_o(busy_o));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Gap cycle after each strobe, so no strobe is assigned twice at one edge
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    n_tests++;
    if (reg_rdata_o !== e) begin
      n_fail++;
      $display("unexpected at %0t: read %h gave %h not %h", $time, a, reg_rdata_o, e);
    end
    @(posedge sys_clk_i);
  endtask

  // Arctangent results may miss the exact code by a few counts
  task automatic smp(input logic [15:0] a, b, e, input int tol, input logic es);
    int k;
    logic [15:0] d;
    logic ok;
    first_axis_raw_i <= a;
    second_axis_raw_i <= b;
    sample_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    sample_valid_i <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end while (angle_valid_o !== 1'b1 && k < 40);
    d = angle_o - e;
    ok = k < 40 && (d <= 16'(tol) || 16'(-d) <= 16'(tol)) && sat_flag_o === es;
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: angle %h flag %b not %h %b", $time, angle_o, sat_flag_o, e, es);
    end
    @(posedge sys_clk_i);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`AC_ADDR_CTRL, 32'h030);
    rd(`AC_ADDR_GAIN, 32'h400);
    rd(`AC_ADDR_LIMITS, 32'h0);
    rd(9'h040, 32'h0);
    ce_i <= 1'b0;
    wr(`AC_ADDR_GAIN, 32'h0);
    ce_i <= 1'b1;
    rd(`AC_ADDR_GAIN, 32'h400);
    for (int i = 0; i < 33; i++) wr(`AC_ADDR_COEFF + 9'(4 * i), 32'h0);
    smp(16'h0000, 16'h4000, 16'h0000, 4, 1'b0);
    smp(16'h4000, 16'h0000, 16'h4000, 4, 1'b0);
    smp(16'h0000, 16'hC000, 16'h8000, 4, 1'b0);
    smp(16'hC000, 16'h0000, 16'hC000, 4, 1'b0);
    wr(`AC_ADDR_CTRL, 32'h032);
    smp(16'h4000, 16'h0000, 16'h0000, 4, 1'b0);
    wr(`AC_ADDR_CTRL, 32'h031);
    smp(16'h8000, 16'h0000, 16'h0000, 0, 1'b0);
    smp(16'h0000, 16'h0000, 16'h8000, 0, 1'b0);
    smp(16'h7FFF, 16'h0000, 16'hFFFF, 0, 1'b0);
    smp(16'h1234, 16'h5678, 16'h9234, 0, 1'b0);
    rd(`AC_ADDR_AXIS, 32'h56781234);
    wr(`AC_ADDR_CTRL, 32'h033);
    smp(16'h1234, 16'h5678, 16'hD678, 0, 1'b0);
    wr(`AC_ADDR_ANGLE, 32'h0);
    rd(`AC_ADDR_ANGLE, 32'hD678);
    wr(`AC_ADDR_CTRL, 32'h035);
    smp(16'h1000, 16'h0000, 16'h7000, 0, 1'b0);
    wr(`AC_ADDR_PRE_OFFS, 32'h0800);
    smp(16'h1000, 16'h0000, 16'h8000, 0, 1'b0);
    wr(`AC_ADDR_CTRL, 32'h031);
    wr(`AC_ADDR_PRE_OFFS, 32'h1000);
    smp(16'h7000, 16'h0000, 16'h1000, 0, 1'b0);
    wr(`AC_ADDR_PRE_OFFS, 32'h0);
    wr(`AC_ADDR_CTRL, 32'h039);
    wr(`AC_ADDR_LIMITS, 32'h8020);
    smp(16'h1000, 16'h0000, 16'h9000, 0, 1'b1);
    smp(16'hD000, 16'h0000, 16'h5000, 0, 1'b0);
    smp(16'h9000, 16'h0000, 16'h1000, 0, 1'b1);
    rd(`AC_ADDR_STATUS, 32'h1);
    wr(`AC_ADDR_CTRL, 32'h021);
    wr(`AC_ADDR_GAIN, 32'h0800);
    smp(16'h1000, 16'h0000, 16'h2000, 0, 1'b0);
    wr(`AC_ADDR_CTRL, 32'h031);
    wr(`AC_ADDR_LIMITS, 32'hC00000);
    smp(16'h1000, 16'h0000, 16'hFFFF, 0, 1'b0);
    smp(16'h0000, 16'h0000, 16'hFFFF, 0, 1'b0);
    smp(16'h4000, 16'h0000, 16'hFFFF, 0, 1'b0);
    smp(16'h5000, 16'h0000, 16'h0000, 0, 1'b0);
    smp(16'hB000, 16'h0000, 16'h6000, 0, 1'b0);
    wr(`AC_ADDR_GAIN, 32'h0);
    smp(16'hB000, 16'h0000, 16'h0000, 0, 1'b0);
    wr(`AC_ADDR_GAIN, 32'h0400);
    wr(`AC_ADDR_POST_OFFS, 32'hF000);
    smp(16'h9000, 16'h0000, 16'h0000, 0, 1'b0);
    wr(`AC_ADDR_CTRL, 32'h011);
    smp(16'h9000, 16'h0000, 16'hF000, 0, 1'b0);
    wr(`AC_ADDR_POST_OFFS, 32'h1000);
    smp(16'h7000, 16'h0000, 16'h1000, 0, 1'b0);
    wr(`AC_ADDR_CTRL, 32'h031);
    smp(16'h7000, 16'h0000, 16'hFFFF, 0, 1'b0);
    wr(`AC_ADDR_POST_OFFS, 32'h0);
    wr(`AC_ADDR_HYST, 32'h10);
    smp(16'h7100, 16'h0000, 16'hF100, 0, 1'b0);
    smp(16'h7108, 16'h0000, 16'hF108, 0, 1'b0);
    smp(16'h7100, 16'h0000, 16'hF108, 0, 1'b0);
    rd(`AC_ADDR_AXIS, 32'h00007108);
    smp(16'h70F0, 16'h0000, 16'hF0F0, 0, 1'b0);
    wr(`AC_ADDR_HYST, 32'h0);
    wr(`AC_ADDR_COEFF, 32'hFC0);
    for (int i = 1; i < 11; i++) wr(`AC_ADDR_COEFF + 9'(4 * i), 32'hFFF);
    wr(`AC_ADDR_COEFF + 9'h02C, 32'h100);
    wr(`AC_ADDR_COEFF + 9'h048, 32'h100);
    for (int m = 0; m < 4; m++) begin
      wr(`AC_ADDR_CTRL, 32'h031 | (32'(m) << 6));
      smp(16'h1000, 16'h0000, lin_exp[m], 0, 1'b0);
    end
    wr(`AC_ADDR_CTRL, 32'h331);
    smp(16'h1000, 16'h0000, 16'h8000, 0, 1'b0);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
endmodule

bind ac_angle_calc ac_angle_calc_monitor u_ac_angle_calc_monitor (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sample_valid_i(sample_valid_i),
  .first_axis_raw_i(first_axis_raw_i), .second_axis_raw_i(second_axis_raw_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .angle_o(angle_o),
  .angle_valid_o(angle_valid_o), .sat_flag_o(sat_flag_o), .busy_o(busy_o));
